// >>> vssp_defs.svh
// Purpose: constants of the voice sample serial port
// Assumes: hclk at 100 MHz, link pins sampled on hclk
// Notes: byte offsets are decoded on haddr[7:0] only
`ifndef VSSP_DEFS_SVH
`define VSSP_DEFS_SVH
// Register byte offsets
`define VSSP_AW 8
`define VSSP_OFF_CTRL 8'h00
`define VSSP_OFF_LINKS 8'h04
`define VSSP_OFF_TX0 8'h08
`define VSSP_OFF_TX1 8'h0c
`define VSSP_OFF_TX2 8'h10
`define VSSP_OFF_RX0 8'h14
`define VSSP_OFF_RX1 8'h18
`define VSSP_OFF_RX2 8'h1c
`define VSSP_OFF_STAT 8'h20
// Control fields
`define VSSP_CTRL_EN 0
`define VSSP_CTRL_MST 1
`define VSSP_CTRL_FRM 2
`define VSSP_CTRL_S16 4
`define VSSP_CTRL_FMT 5
`define VSSP_CTRL_LSB 7
`define VSSP_CTRL_PAD 8
`define VSSP_CTRL_ATT 10
`define VSSP_CTRL_MUTE 13
`define VSSP_CTRL_FSOFF 14
`define VSSP_CTRL_CLK 15
`define VSSP_CTRL_EARLY 17
`define VSSP_CTRL_W 18
`define VSSP_CTRL_RST 18'h00000
// Link map fields: enable at stride*i, slot number above it
`define VSSP_LINKS_W 9
`define VSSP_LINKS_RST 9'h000
`define VSSP_LINK_STRIDE 3
`define VSSP_TX_RST 16'h0000
// Timing
`define VSSP_HCLK_KHZ 100000
`define VSSP_BCLK0_KHZ 128
`define VSSP_BCLK1_KHZ 256
`define VSSP_BCLK2_KHZ 512
`define VSSP_FRAME_KHZ 8
`define VSSP_HALF(k) (`VSSP_HCLK_KHZ / (2 * (k)))
`define VSSP_FBITS(k) ((k) / `VSSP_FRAME_KHZ)
`define VSSP_SLAVE_MAX_KHZ 2048
`define VSSP_GCI_MAX_KHZ 4096
`define VSSP_LSYNC_MAX_NS 62500
`define VSSP_LSYNC_BITS 7'h08
// Slot geometry
`define VSSP_SPAN16 7'h40
`define VSSP_SPAN8 7'h20
`define VSSP_LAST16 4'hf
`define VSSP_LAST8 4'h7
`endif

// >>> vssp_pkg.sv
// Purpose: types of the voice sample serial port
// Assumes: constants live in vssp_defs.svh
// Notes: companded codes pass through untouched
package vssp_pkg;
   typedef enum logic [1:0] {
      VSSP_LONG = 2'b00,
      VSSP_SHORT = 2'b01,
      VSSP_GCI = 2'b10
   } vssp_frame_t;
   typedef enum logic [1:0] {
      VSSP_MULAW = 2'b00,
      VSSP_ALAW = 2'b01,
      VSSP_LIN13 = 2'b10,
      VSSP_LIN16 = 2'b11
   } vssp_fmt_t;
   typedef enum logic [1:0] {
      VSSP_PAD_SIGN = 2'b00,
      VSSP_PAD_ZERO = 2'b01,
      VSSP_PAD_ATT = 2'b10
   } vssp_pad_t;
   typedef enum logic {
      VSSP_IDLE = 1'b0,
      VSSP_RUN = 1'b1
   } vssp_state_t;
endpackage

// >>> vssp_link.sv
// Purpose: one voice link, slot match, word format and serial shifting
// Assumes: strobes and frame position come from vssp_port
// Notes: word is latched at the first bit so writes never tear a slot
`timescale 1ns/1ps
module vssp_link
   import vssp_pkg::*;
(
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Link setup
   input wire logic link_en,
   input wire logic [1:0] link_slot,
   input wire logic [15:0] tx_word,
   // Format
   input wire logic slot16,
   input wire logic [1:0] fmt,
   input wire logic lsb_first,
   input wire logic [1:0] pad,
   input wire logic [2:0] atten,
   // Frame position
   input wire logic in_frame,
   input wire logic [1:0] cur_slot,
   input wire logic [3:0] pos,
   input wire logic slot_last,
   input wire logic launch,
   input wire logic sample,
   input wire logic rx_bit,
   // Results
   output logic hit,
   output logic tx_bit,
   output logic [15:0] rx_word
);
   logic [15:0] w, m, sh_q, sh_d, rs_q, rs_d, rx_q, rx_d;
   logic [3:0] bi;
   logic sign;
   logic [2:0] fill;

   // Slot match, slot word build and receive extraction
   always_comb begin
      hit = link_en && in_frame && (cur_slot == link_slot);
      if (lsb_first) begin
         bi = slot16 ? pos : pos + 4'h8;
      end else begin
         bi = 4'hf - pos;
      end
      sign = pad == VSSP_PAD_SIGN;
      fill = (pad == VSSP_PAD_ATT) ? atten : 3'h0;
      if (!slot16) begin
         w = {tx_word[7:0], 8'h00};
      end else begin
         case (fmt)
            VSSP_LIN16: w = tx_word;
            VSSP_LIN13: w = sign ? {{3{tx_word[12]}}, tx_word[12:0]} : {tx_word[12:0], fill};
            default: w = sign ? {{8{tx_word[7]}}, tx_word[7:0]} : {tx_word[7:0], 5'h00, fill};
         endcase
      end
      sh_d = (launch && hit && pos == 4'h0) ? w : sh_q;
      tx_bit = (pos == 4'h0) ? w[bi] : sh_q[bi];
      m = rs_q;
      m[bi] = rx_bit;
      rs_d = (sample && hit) ? m : rs_q;
      rx_d = rx_q;
      if (sample && hit && slot_last) begin
         if (!slot16) begin
            rx_d = {8'h00, m[15:8]};
         end else begin
            case (fmt)
               VSSP_LIN16: rx_d = m;
               VSSP_LIN13: rx_d = sign ? {3'h0, m[12:0]} : {3'h0, m[15:3]};
               default: rx_d = sign ? {8'h00, m[7:0]} : {8'h00, m[15:8]};
            endcase
         end
      end
   end

   // Shift and result registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sh_q <= 16'h0000;
         rs_q <= 16'h0000;
         rx_q <= 16'h0000;
      end else begin
         sh_q <= sh_d;
         rs_q <= rs_d;
         rx_q <= rx_d;
      end
   end

   assign rx_word = rx_q;
endmodule

// >>> vssp_port.sv
// Purpose: voice sample serial port with AHB-Lite registers
// Assumes: link pins are asynchronous to hclk and pass two flip-flops
// Notes: master clock rates are hclk divided, so slightly fast
//
// Added by the designer: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps
`include "vssp_defs.svh"
module vssp_port
   import vssp_pkg::*;
(
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Bit clock pin
   input wire logic bclk_i,
   output logic bclk_o,
   output logic bclk_oe_n,
   // Frame marker pin
   input wire logic fsync_i,
   output logic fsync_o,
   output logic fsync_oe_n,
   // Serial data pins
   input wire logic sdin,
   output logic sdout,
   output logic sdout_oe_n
);
   // Registers
   logic [`VSSP_CTRL_W-1:0] ctrl_q, ctrl_d;
   logic [`VSSP_LINKS_W-1:0] links_q, links_d;
   logic [15:0] tx_q [0:2];
   logic [15:0] tx_d [0:2];
   logic [15:0] rx_w [0:2];
   logic wr_pend_q, wr_pend_d;
   logic [`VSSP_AW-1:0] wr_addr_q, wr_addr_d;
   logic [31:0] hrdata_q, rd_d;
   logic hready_q, hresp_q;
   logic addr_ph;
   // Pin synchronisers
   logic [2:0] sy1_q, sy2_q;
   logic bc3_q;
   // Configuration views
   logic en, master, long_like, gci, slot16, lsb_first, mute, early;
   logic [1:0] fmt_e;
   // Master clock generator
   logic [8:0] div_q, div_d, half;
   logic [6:0] mbit_q, mbit_d, fbits;
   logic bclk_q, bclk_d, fso_q, fso_d;
   logic m_rise, m_fall, rise, fall;
   logic bclk_oe_n_q, fs_oe_n_q;
   // Frame engine
   vssp_state_t state_q, state_d;
   logic [6:0] idx_q, idx_d, span;
   logic [7:0] fcnt_q, fcnt_d;
   logic fs_now, fs_prev_q, start_l, launch_q, launch_d;
   logic [1:0] cur_slot;
   logic [3:0] pos;
   logic slot_last, in_frame;
   // Serial output
   logic [2:0] hit, tbit;
   logic tx_sel, sdout_q, sdout_d, oe_n_q, oe_n_d;

   // Two flip-flops on each pin; bc3 only delays the settled clock
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sy1_q <= 3'h0;
         sy2_q <= 3'h0;
         bc3_q <= 1'b0;
      end else begin
         sy1_q <= {sdin, fsync_i, bclk_i};
         sy2_q <= sy1_q;
         bc3_q <= sy2_q[0];
      end
   end

   // Effective configuration; GCI forces 8-period slots for the B channels
   always_comb begin
      en = ctrl_q[`VSSP_CTRL_EN];
      master = ctrl_q[`VSSP_CTRL_MST];
      gci = ctrl_q[`VSSP_CTRL_FRM +: 2] == VSSP_GCI;
      long_like = ctrl_q[`VSSP_CTRL_FRM +: 2] != VSSP_SHORT;
      slot16 = ctrl_q[`VSSP_CTRL_S16] && !gci;
      lsb_first = ctrl_q[`VSSP_CTRL_LSB];
      mute = ctrl_q[`VSSP_CTRL_MUTE];
      early = ctrl_q[`VSSP_CTRL_EARLY];
      // Wide formats in short slots fall back to 8-bit
      fmt_e = slot16 ? ctrl_q[`VSSP_CTRL_FMT +: 2] : VSSP_MULAW;
   end

   // Master bit clock divider and marker generator
   always_comb begin
      case (ctrl_q[`VSSP_CTRL_CLK +: 2])
         2'b00: begin
            half = 9'(`VSSP_HALF(`VSSP_BCLK0_KHZ));
            fbits = 7'(`VSSP_FBITS(`VSSP_BCLK0_KHZ));
         end
         2'b01: begin
            half = 9'(`VSSP_HALF(`VSSP_BCLK1_KHZ));
            fbits = 7'(`VSSP_FBITS(`VSSP_BCLK1_KHZ));
         end
         default: begin
            half = 9'(`VSSP_HALF(`VSSP_BCLK2_KHZ));
            fbits = 7'(`VSSP_FBITS(`VSSP_BCLK2_KHZ));
         end
      endcase
      div_d = div_q;
      bclk_d = bclk_q;
      mbit_d = mbit_q;
      fso_d = fso_q;
      m_rise = 1'b0;
      m_fall = 1'b0;
      if (en && master) begin
         if (div_q >= half - 9'h001) begin
            div_d = 9'h000;
            bclk_d = !bclk_q;
            m_rise = !bclk_q;
            m_fall = bclk_q;
         end else begin
            div_d = div_q + 9'h001;
         end
         if (m_rise) begin
            mbit_d = (mbit_q >= fbits - 7'h01) ? 7'h00 : mbit_q + 7'h01;
            if (ctrl_q[`VSSP_CTRL_FSOFF]) begin
               fso_d = 1'b0;
            end else if (long_like && !gci) begin
               fso_d = mbit_d < `VSSP_LSYNC_BITS;
            end else begin
               fso_d = mbit_d == 7'h00;
            end
         end
      end else begin
         // Park so the first rising edge opens a frame unless the enabling write selects a faster clock
         div_d = 9'h000;
         bclk_d = 1'b0;
         mbit_d = fbits - 7'h01;
         fso_d = 1'b0;
      end
   end

   // Master generator registers and pin enables
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         div_q <= 9'h000;
         bclk_q <= 1'b0;
         mbit_q <= 7'h00;
         fso_q <= 1'b0;
         bclk_oe_n_q <= 1'b1;
         fs_oe_n_q <= 1'b1;
      end else begin
         div_q <= div_d;
         bclk_q <= bclk_d;
         mbit_q <= mbit_d;
         fso_q <= fso_d;
         bclk_oe_n_q <= !(en && master);
         fs_oe_n_q <= !(en && master);
      end
   end

   // Edge strobes from the own divider or from the settled pin clock
   always_comb begin
      rise = en && (master ? m_rise : (sy2_q[0] && !bc3_q));
      fall = en && (master ? m_fall : (!sy2_q[0] && bc3_q));
      fs_now = master ? fso_d : sy2_q[1];
      // Marker rise may come at any time; held highs do not restart
      start_l = en && long_like && fs_now && !fs_prev_q;
   end

   // Slot position decode
   always_comb begin
      if (slot16) begin
         span = `VSSP_SPAN16;
         cur_slot = idx_q[5:4];
         pos = idx_q[3:0];
         slot_last = pos == `VSSP_LAST16;
      end else begin
         span = `VSSP_SPAN8;
         cur_slot = idx_q[4:3];
         pos = {1'b0, idx_q[2:0]};
         slot_last = pos == `VSSP_LAST8;
      end
      in_frame = (state_q == VSSP_RUN) && (idx_q < span);
   end

   // Frame engine: idx is the bit that the next falling edge samples
   always_comb begin
      state_d = state_q;
      idx_d = idx_q;
      fcnt_d = fcnt_q;
      launch_d = rise || start_l;
      case (state_q)
         VSSP_IDLE: begin
            idx_d = idx_q;
         end
         VSSP_RUN: begin
            if (fall) begin
               idx_d = idx_q + 7'h01;
               if (idx_d >= span) begin
                  state_d = VSSP_IDLE;
               end
            end
         end
         default: begin
            state_d = VSSP_IDLE;
         end
      endcase
      if (fall && !long_like && fs_now) begin
         idx_d = 7'h00;
         state_d = VSSP_RUN;
         fcnt_d = fcnt_q + 8'h01;
      end
      if (start_l) begin
         idx_d = 7'h00;
         state_d = VSSP_RUN;
         fcnt_d = fcnt_q + 8'h01;
      end
      if (!en) begin
         state_d = VSSP_IDLE;
      end
   end

   // Frame engine registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_q <= VSSP_IDLE;
         idx_q <= 7'h00;
         fcnt_q <= 8'h00;
         fs_prev_q <= 1'b0;
         launch_q <= 1'b0;
      end else begin
         state_q <= state_d;
         idx_q <= idx_d;
         fcnt_q <= fcnt_d;
         fs_prev_q <= fs_now;
         launch_q <= launch_d;
      end
   end

   // Three links; launch comes one cycle late so idx is already updated
   for (genvar i = 0; i < 3; i++) begin : g_link
      vssp_link u_link (
         .hclk (hclk),
         .hresetn (hresetn),
         .link_en (links_q[`VSSP_LINK_STRIDE*i]),
         .link_slot (links_q[`VSSP_LINK_STRIDE*i+1 +: 2]),
         .tx_word (tx_q[i]),
         .slot16 (slot16),
         .fmt (fmt_e),
         .lsb_first (lsb_first),
         .pad (ctrl_q[`VSSP_CTRL_PAD +: 2]),
         .atten (ctrl_q[`VSSP_CTRL_ATT +: 3]),
         .in_frame (in_frame),
         .cur_slot (cur_slot),
         .pos (pos),
         .slot_last (slot_last),
         .launch (launch_q),
         .sample (fall && state_q == VSSP_RUN),
         .rx_bit (sy2_q[2]),
         .hit (hit[i]),
         .tx_bit (tbit[i]),
         .rx_word (rx_w[i])
      );
   end

   // Serial output; two links on one slot give the lower link the pin
   always_comb begin
      tx_sel = hit[0] ? tbit[0] : (hit[1] ? tbit[1] : tbit[2]);
      sdout_d = sdout_q;
      oe_n_d = oe_n_q;
      if (!en) begin
         oe_n_d = 1'b1;
      end else if (launch_q) begin
         if (|hit) begin
            oe_n_d = 1'b0;
            sdout_d = mute ? 1'b0 : tx_sel;
         end else begin
            oe_n_d = 1'b1;
         end
      end else if (fall && early && (|hit) && slot_last) begin
         oe_n_d = 1'b1;
      end
   end

   // Serial output registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sdout_q <= 1'b0;
         oe_n_q <= 1'b1;
      end else begin
         sdout_q <= sdout_d;
         oe_n_q <= oe_n_d;
      end
   end

   // Bus writes land in the data phase; reads of CTRL, LINKS and TX see the next values, RX and STAT the current ones
   always_comb begin
      addr_ph = hsel && hready && htrans[1];
      wr_pend_d = addr_ph && hwrite;
      wr_addr_d = addr_ph ? haddr[`VSSP_AW-1:0] : wr_addr_q;
      ctrl_d = ctrl_q;
      links_d = links_q;
      tx_d = tx_q;
      if (wr_pend_q) begin
         case (wr_addr_q)
            `VSSP_OFF_CTRL: ctrl_d = hwdata[`VSSP_CTRL_W-1:0];
            `VSSP_OFF_LINKS: links_d = hwdata[`VSSP_LINKS_W-1:0];
            `VSSP_OFF_TX0: tx_d[0] = hwdata[15:0];
            `VSSP_OFF_TX1: tx_d[1] = hwdata[15:0];
            `VSSP_OFF_TX2: tx_d[2] = hwdata[15:0];
            default: ctrl_d = ctrl_q;
         endcase
      end
      rd_d = 32'h0000_0000;
      if (addr_ph && !hwrite) begin
         case (haddr[`VSSP_AW-1:0])
            `VSSP_OFF_CTRL: rd_d = {14'h0000, ctrl_d};
            `VSSP_OFF_LINKS: rd_d = {23'h000000, links_d};
            `VSSP_OFF_TX0: rd_d = {16'h0000, tx_d[0]};
            `VSSP_OFF_TX1: rd_d = {16'h0000, tx_d[1]};
            `VSSP_OFF_TX2: rd_d = {16'h0000, tx_d[2]};
            `VSSP_OFF_RX0: rd_d = {16'h0000, rx_w[0]};
            `VSSP_OFF_RX1: rd_d = {16'h0000, rx_w[1]};
            `VSSP_OFF_RX2: rd_d = {16'h0000, rx_w[2]};
            `VSSP_OFF_STAT: rd_d = {16'h0000, fcnt_q, 6'h00, sy2_q[0], state_q};
            default: rd_d = 32'h0000_0000;
         endcase
      end
   end

   // Bus registers; zero wait states, always OKAY
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_q <= `VSSP_CTRL_RST;
         links_q <= `VSSP_LINKS_RST;
         tx_q[0] <= `VSSP_TX_RST;
         tx_q[1] <= `VSSP_TX_RST;
         tx_q[2] <= `VSSP_TX_RST;
         wr_pend_q <= 1'b0;
         wr_addr_q <= 8'h00;
         hrdata_q <= 32'h0000_0000;
         hready_q <= 1'b1;
         hresp_q <= 1'b0;
      end else begin
         ctrl_q <= ctrl_d;
         links_q <= links_d;
         tx_q <= tx_d;
         wr_pend_q <= wr_pend_d;
         wr_addr_q <= wr_addr_d;
         hrdata_q <= rd_d;
         hready_q <= 1'b1;
         hresp_q <= 1'b0;
      end
   end

   // Outputs straight from flip-flops
   assign hrdata = hrdata_q;
   assign hreadyout = hready_q;
   assign hresp = hresp_q;
   assign bclk_o = bclk_q;
   assign bclk_oe_n = bclk_oe_n_q;
   assign fsync_o = fso_q;
   assign fsync_oe_n = fs_oe_n_q;
   assign sdout = sdout_q;
   assign sdout_oe_n = oe_n_q;
endmodule

// >>> vssp_port_checker.sv
// Purpose: timing checks on the voice port pins and bus answers
// Assumes: hclk domain only; master pins judged while the device drives them
// Notes: bound to vssp_port after the module
`timescale 1ns/1ps
`include "vssp_defs.svh"
module vssp_port_checker (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Bus
   input wire logic hsel,
   input wire logic hready,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   // Link pins
   input wire logic bclk_o,
   input wire logic bclk_oe_n,
   input wire logic fsync_o,
   input wire logic fsync_oe_n,
   input wire logic sdout,
   input wire logic sdout_oe_n
);
   logic bk_q, bk_qq, fs_q, tg_q, tg_d;
   logic [9:0] hc_q, hc_d;
   logic [3:0] mk_q, mk_d;
   // Half period length and marker rise count; the first half after enable is not judged
   always_comb begin
      hc_d = (bclk_o != bk_q) ? 10'h001 : hc_q + 10'h001;
      tg_d = bclk_oe_n ? 1'b0 : (tg_q | (bclk_o != bk_q));
      mk_d = (fsync_o && !fs_q) ? 4'h0 : ((fsync_o && bclk_o && !bk_q) ? mk_q + 4'h1 : mk_q);
   end
   // Edge history registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         bk_q <= 1'b0;
         bk_qq <= 1'b0;
         fs_q <= 1'b0;
         tg_q <= 1'b0;
         hc_q <= 10'h000;
         mk_q <= 4'h0;
      end else begin
         bk_q <= bclk_o;
         bk_qq <= bk_q;
         fs_q <= fsync_o;
         tg_q <= tg_d;
         hc_q <= hc_d;
         mk_q <= mk_d;
      end
   end
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence mk_fall_s;
      !fsync_oe_n ##0 $fell(fsync_o);
   endsequence
   hready_one_a: assert property (hreadyout == 1'b1)
      else $error("bus wait state inserted");
   resp_okay_a: assert property (hresp == 1'b0)
      else $error("bus error response");
   rdata_idle_a: assert property (!(hsel && hready && htrans[1] && !hwrite) |=> hrdata == 32'h0)
      else $error("read data outside a read data phase");
   oe_pair_a: assert property (bclk_oe_n == fsync_oe_n)
      else $error("clock and marker drive differ");
   marker_len_a: assert property (mk_fall_s |-> (mk_q == 4'h7 || mk_q == 4'h0))
      else $error("marker length wrong");
   launch_rise_a: assert property ($changed(sdout) && !sdout_oe_n && !bclk_oe_n |-> bk_q && !bk_qq)
      else $error("serial output changed away from a rising edge");
   // Early release lands with the falling edge itself, late release trails the rise by one cycle
   release_edge_a: assert property ($rose(sdout_oe_n) && !bclk_oe_n |->
      (bk_q && !bclk_o) || (bk_q && !bk_qq))
      else $error("serial output released away from a clock edge");
   bclk_half_a: assert property ($changed(bclk_o) && tg_q && !bclk_oe_n |->
      hc_q inside {`VSSP_HALF(`VSSP_BCLK0_KHZ), `VSSP_HALF(`VSSP_BCLK1_KHZ),
      `VSSP_HALF(`VSSP_BCLK2_KHZ)})
      else $error("bit clock half period wrong");
endmodule
bind vssp_port vssp_port_checker chk_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
   .hready(hready), .htrans(htrans), .hwrite(hwrite), .hrdata(hrdata),
   .hreadyout(hreadyout), .hresp(hresp), .bclk_o(bclk_o), .bclk_oe_n(bclk_oe_n),
   .fsync_o(fsync_o), .fsync_oe_n(fsync_oe_n), .sdout(sdout), .sdout_oe_n(sdout_oe_n));

// >>> vssp_codec_model.sv
// Purpose: far side codec, clock source in slave mode, bit capture
// Assumes: pins resolved by the bench; released lines read as pull-down
// Notes: the slave clock stands low between frames
`timescale 1ns/1ps
module vssp_codec_model (
   // Mode
   input wire logic short_m,
   input wire logic slv_run,
   input wire logic [63:0] pat,
   // Resolved pins
   input wire logic bclk_w,
   input wire logic fsync_w,
   input wire logic sdout_w,
   input wire logic sdout_drv,
   // Codec drive and capture
   output logic bclk_c,
   output logic fsync_c,
   output logic sdin,
   output logic [63:0] cap_v,
   output logic [63:0] drv_v
);
   int pos = 64;
   int i;
   initial begin
      bclk_c = 1'b0;
      fsync_c = 1'b0;
      sdin = 1'b0;
      cap_v = 64'h0;
      drv_v = 64'h0;
   end
   // Frames of 64 bits; a short marker needs one lead period before bit 0
   always begin
      wait (slv_run);
      for (i = short_m ? -1 : 0; i < 64; i++) begin
         bclk_c = 1'b1;
         fsync_c = short_m ? (i == -1) : (i < 8);
         #62.5;
         bclk_c = 1'b0;
         #62.5;
      end
      fsync_c = 1'b0;
      #500;
   end
   // Long marker rise restarts the bit count
   always @(posedge fsync_w) if (!short_m) pos = 0;
   // Sample on falls, as a codec would
   always @(negedge bclk_w) begin
      if (short_m && fsync_w) begin
         pos = 0;
      end else if (pos < 64) begin
         cap_v[63 - pos] = sdout_w;
         drv_v[63 - pos] = sdout_drv;
         pos = pos + 1;
      end
   end
   // Input changes shortly after a rise, clear of the sampling fall
   always @(posedge bclk_w) begin
      #20;
      if (pos < 64) sdin = pat[63 - pos];
   end
endmodule

// >>> test_voice_sample_serial_port.sv
// Purpose: self-checking bench of the voice sample serial port
// Assumes: zero-wait bus, codec model on the link pins
// Notes: master tests run at the fastest clock to keep the run short
`timescale 1ns/1ps
`include "vssp_defs.svh"
`define VSSP_CHK(got, exp) \
   begin \
      n_checks++; \
      if ((got) !== (exp)) begin \
         err_count++; \
         $display("[ERR] t=%0t got=%h exp=%h", $time, (got), (exp)); \
      end \
   end
module test_voice_sample_serial_port;
   logic hclk = 1'b0;
   logic hresetn, hsel, hwrite, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic bclk_o, bclk_oe_n, fsync_o, fsync_oe_n, sdout, sdout_oe_n;
   logic bclk_w, fsync_w, sdout_w, sdout_en, bclk_c, fsync_c, sdin, short_m, slv_run;
   logic [63:0] pat, cap_v, drv_v;
   int err_count = 0;
   int n_checks = 0;
   int cyc = 0;
   int kh[3] = '{`VSSP_BCLK0_KHZ, `VSSP_BCLK1_KHZ, `VSSP_BCLK2_KHZ};
   always #5 hclk = ~hclk;
   // Pin resolution; undriven lines fall to the pull-down level
   // The data pad settles 1 ns late, so a codec sees the old bit at a shared edge
   assign bclk_w = !bclk_oe_n ? bclk_o : bclk_c;
   assign fsync_w = !fsync_oe_n ? fsync_o : fsync_c;
   assign #1 sdout_w = !sdout_oe_n ? sdout : 1'b0;
   assign #1 sdout_en = !sdout_oe_n;
   vssp_port dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
      .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .bclk_i(bclk_w), .bclk_o(bclk_o), .bclk_oe_n(bclk_oe_n), .fsync_i(fsync_w),
      .fsync_o(fsync_o), .fsync_oe_n(fsync_oe_n), .sdin(sdin), .sdout(sdout),
      .sdout_oe_n(sdout_oe_n));
   vssp_codec_model codec_u (.short_m(short_m), .slv_run(slv_run), .pat(pat),
      .bclk_w(bclk_w), .fsync_w(fsync_w), .sdout_w(sdout_w), .sdout_drv(sdout_en),
      .bclk_c(bclk_c), .fsync_c(fsync_c), .sdin(sdin), .cap_v(cap_v), .drv_v(drv_v));
   // One single bus transfer; read data lands in rd
   task automatic bus_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h000000, a};
      htrans <= 2'b10;
      hwrite <= wr;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
      hsel <= 1'b0;
   endtask
   task automatic t_regs();
      bus_xfer(1'b0, `VSSP_OFF_CTRL, 32'h0);
      `VSSP_CHK(rd, 32'h0)
      bus_xfer(1'b1, `VSSP_OFF_LINKS, 32'hffffffff);
      bus_xfer(1'b0, `VSSP_OFF_LINKS, 32'h0);
      `VSSP_CHK(rd, 32'h000001ff)
      bus_xfer(1'b1, `VSSP_OFF_RX1, 32'h0000abcd);
      bus_xfer(1'b0, `VSSP_OFF_RX1, 32'h0);
      `VSSP_CHK(rd, 32'h0)
      bus_xfer(1'b0, 8'h40, 32'h0);
      `VSSP_CHK(rd, 32'h0)
      bus_xfer(1'b1, `VSSP_OFF_LINKS, 32'h0);
      `VSSP_CHK({bclk_oe_n, fsync_oe_n, sdout_oe_n}, 3'b111)
      $display("registers test done");
   endtask
   // Every master rate, with the marker held off
   task automatic t_clock();
      realtime t0;
      int k;
      for (k = 0; k < 3; k++) begin
         bus_xfer(1'b1, `VSSP_OFF_CTRL, 32'h00004003 | (k << 15));
         repeat (3) @(posedge bclk_o);
         t0 = $realtime;
         @(posedge bclk_o);
         `VSSP_CHK(int'(($realtime - t0) / 10.0), 2 * `VSSP_HALF(kh[k]))
         `VSSP_CHK({fsync_oe_n, fsync_w}, 2'b00)
         bus_xfer(1'b1, `VSSP_OFF_CTRL, 32'h0);
      end
      $display("clock test done");
   endtask
   // Long marker master, 8-bit slots, links on slots 0 and 2
   task automatic t_master(input logic early, input logic mute);
      logic [63:0] exp_cap;
      short_m = 1'b0;
      pat = {8'h96, 8'hff, 8'h5a, 40'h0};
      exp_cap = mute ? 64'h0 : {8'ha5, 8'h00, 8'h3c, 40'h0};
      bus_xfer(1'b1, `VSSP_OFF_TX0, 32'h000000a5);
      bus_xfer(1'b1, `VSSP_OFF_TX1, 32'h0000003c);
      bus_xfer(1'b1, `VSSP_OFF_LINKS, 32'h00000029);
      bus_xfer(1'b1, `VSSP_OFF_CTRL, {14'h0, early, 2'b10, 1'b0, mute, 13'h0003});
      repeat (2) @(posedge fsync_w);
      `VSSP_CHK(cap_v, exp_cap)
      `VSSP_CHK(drv_v, 64'hff00ff0000000000)
      bus_xfer(1'b0, `VSSP_OFF_RX0, 32'h0);
      `VSSP_CHK(rd, 32'h00000096)
      bus_xfer(1'b0, `VSSP_OFF_RX1, 32'h0);
      `VSSP_CHK(rd, 32'h0000005a)
      bus_xfer(1'b1, `VSSP_OFF_CTRL, 32'h0);
      $display("master test done");
   endtask
   // Short marker slave, 16-bit linear, LSB first, link 2 on slot 2
   task automatic t_slave();
      short_m = 1'b1;
      pat = {32'h0, 16'hf77d, 16'h0};
      bus_xfer(1'b1, `VSSP_OFF_TX2, 32'h00001234);
      bus_xfer(1'b1, `VSSP_OFF_LINKS, 32'h00000140);
      bus_xfer(1'b1, `VSSP_OFF_CTRL, 32'h000000f5);
      slv_run = 1'b1;
      repeat (3) @(posedge fsync_w);
      `VSSP_CHK(cap_v, {32'h0, 16'h2c48, 16'h0})
      `VSSP_CHK(drv_v, 64'h00000000ffff0000)
      `VSSP_CHK({bclk_oe_n, fsync_oe_n}, 2'b11)
      bus_xfer(1'b0, `VSSP_OFF_RX2, 32'h0);
      `VSSP_CHK(rd, 32'h0000beef)
      slv_run = 1'b0;
      bus_xfer(1'b1, `VSSP_OFF_CTRL, 32'h0);
      $display("slave test done");
   endtask
   // Long marker slave, 13-bit samples with attenuation padding, link 0 on slot 1
   task automatic t_slave_long();
      // Let the codec finish the frame it was in when the last test stopped it
      repeat (1000) @(posedge hclk);
      short_m = 1'b0;
      pat = {16'h0, 16'h9c3a, 32'h0};
      bus_xfer(1'b1, `VSSP_OFF_TX0, 32'h00001abc);
      bus_xfer(1'b1, `VSSP_OFF_LINKS, 32'h00000003);
      bus_xfer(1'b1, `VSSP_OFF_CTRL, 32'h00001651);
      slv_run = 1'b1;
      repeat (3) @(posedge fsync_w);
      `VSSP_CHK(cap_v, {16'h0, 16'hd5e5, 32'h0})
      `VSSP_CHK(drv_v, 64'h0000ffff00000000)
      bus_xfer(1'b0, `VSSP_OFF_RX0, 32'h0);
      `VSSP_CHK(rd, 32'h00001387)
      slv_run = 1'b0;
      bus_xfer(1'b1, `VSSP_OFF_CTRL, 32'h0);
      $display("slave long test done");
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // Hang guard, well above the longest expected run
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (cyc == 90000) begin
         err_count++;
         tally_and_finish();
      end
   end
   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      short_m = 1'b0;
      slv_run = 1'b0;
      pat = 64'h0;
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      t_regs();
      t_clock();
      t_master(1'b0, 1'b0);
      t_master(1'b1, 1'b1);
      t_slave();
      t_slave_long();
      tally_and_finish();
   end
endmodule
